// ---- hdl/etm_map.vh ----
// register map and field positions for the e1 transmit maintenance block
// included by etm_tx_maint.v only
`ifndef ETM_MAP_VH
`define ETM_MAP_VH
// printed offsets are not all multiples of four: these are indices, byte address = 4*index
`define ETM_IDX_MAINT      8'h6c
`define ETM_IDX_IRQ_EN     8'h6d
`define ETM_IDX_STATUS     8'h6e
`define ETM_IDX_INJECT     8'h6f
`define ETM_IDX_MODE       8'h70
`define ETM_RST_BYTE       8'h00
`define ETM_RST_MODE       8'h07
// maintenance fields
`define ETM_B_FORCE_ONES   0
`define ETM_B_FORCE_ZEROS  1
`define ETM_B_REALIGN      2
// event / enable fields
`define ETM_B_BASIC        0
`define ETM_B_CRCMF        1
`define ETM_B_SIGMF        2
`define ETM_B_FAS          3
`define ETM_B_SUBMF        4
// injection fields
`define ETM_B_FAS1         0
`define ETM_B_FASALL       1
`define ETM_B_NFAS         2
`define ETM_B_SIGP         3
`define ETM_B_CRCP         4
`define ETM_B_CRC          5
// mode fields
`define ETM_B_MODE_CRC     0
`define ETM_B_MODE_CAS     1
`define ETM_B_MODE_BASIC   2
`define ETM_RESP_OKAY      2'b00
`define ETM_RESP_SLVERR    2'b10
`endif

// ---- hdl/etm_tx_maint.v ----
// transmit-side e1 frame maintenance, event flags and one-shot error injection
// assumes the frame generator supplies one bit per tx_bit_valid with position strobes
// Behaviour
// R1: every change of realign_toggle deletes or repeats exactly one outgoing bit.
// R2: while tx_force_zeros is 1 every outgoing bit is zero.
// R3: while tx_force_ones is 1 every outgoing bit is one.
// R4: sub-multiframe and alignment-word flags set at the first bit of those structures.
// R5: signalling-multiframe, crc-multiframe and basic-frame flags set at their first bits.
// R6: each event flag stays set until software writes a one to it; zero leaves it.
// R7: the interrupt is active while any flag and its matching enable are both one.
// R8: a rising crc_bits_flip inverts all four crc bits of one sub-multiframe.
// R9: a rising crc_align_flip inverts one whole crc multiframe alignment pattern.
// R10: a rising sig_align_flip inverts one whole signalling multiframe alignment pattern.
// R11: a rising non_align_bit_flip inverts one non-alignment bit of an odd frame.
// R12: a rising align_word_flip inverts one complete seven-bit alignment word.
// R13: a rising align_single_bit_flip inverts one alignment-word bit of one even frame.
// R14: each injection control bit clears itself once its inversion has been sent.
// R15: force-zeros wins over force-ones when both are set.
// R16: a request whose structure is not generated is dropped and its bit self-clears.
//
// The AXI4-Lite slave port is this design's own decision.
`timescale 1ns/1ps
`include "etm_map.vh"

module etm_tx_maint (
  // clock and reset
  input  wire        aclk,
  input  wire        aresetn,
  // axi4-lite write address
  input  wire [11:0] s_axi_awaddr,
  input  wire        s_axi_awvalid,
  output reg         s_axi_awready,
  // axi4-lite write data
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output reg         s_axi_wready,
  // axi4-lite write response
  output reg  [1:0]  s_axi_bresp,
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  // axi4-lite read address
  input  wire [11:0] s_axi_araddr,
  input  wire        s_axi_arvalid,
  output reg         s_axi_arready,
  // axi4-lite read data
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready,
  // frame generator stream in
  input  wire        tx_bit_valid,
  input  wire        tx_bit_in,
  input  wire        pos_basic_first,
  input  wire        pos_fas_first,
  input  wire        pos_fas_bit,
  input  wire        pos_nfas_bit,
  input  wire        pos_crc_bit,
  input  wire        pos_submf_first,
  input  wire        pos_crcmf_first,
  input  wire        pos_crc_align_bit,
  input  wire        pos_sigmf_first,
  input  wire        pos_sig_align_bit,
  // stream out
  output reg         tx_bit_out,
  output reg         tx_bit_out_valid,
  // interrupt
  output reg         irq
);

  reg  [2:0]  maint_q;
  reg  [4:0]  irq_en_q;
  reg  [4:0]  status_q;
  reg  [5:0]  inject_q;
  reg  [2:0]  mode_q;
  reg  [5:0]  armed_q;
  reg  [5:0]  active_q;
  reg         realign_prev_q;
  reg         slip_pend_q;
  reg         slip_dir_q;
  reg         rep_pend_q;
  reg         last_bit_q;
  reg  [11:0] wr_addr_q;
  reg         aw_have_q;
  reg  [31:0] wr_data_q;
  reg  [3:0]  wr_strb_q;
  reg         w_have_q;

  // timing notes for whoever integrates this block
  // register bus: awready and wready pulse together while idle, so an address
  //   and data offered together are taken on the same edge; the write lands on
  //   the edge that raises bvalid, two edges after the later handshake
  // a new address may be taken while bvalid still waits for bready; it is then
  //   held until the pending response has been accepted
  // reads: rvalid and the data follow the address handshake by one edge;
  //   arready stays low while rvalid waits
  // only byte lane 0 writes; a word with wstrb[0] low answers but changes nothing
  // stream: each valid input bit that a slip does not delete leaves one edge later on tx_bit_out; a repeated
  //   bit leaves on the following idle cycle, so the generator must leave at
  //   least one idle cycle after each valid bit
  // event flags show one edge after their position strobe, irq one edge later
  // injections: a request waits, armed, for the first bit of its structure;
  //   multi-bit kinds stay active until the next start of that structure; the whole alignment-word kind only until the next frame starts
  // clearing a mode bit drops armed and active requests of that kind at once,
  //   which keeps their control bits from sticking at one
  // the slip choice depends on the bit in flight rather than on a random source,
  //   which keeps the block deterministic under test

  // register index from a byte address; address bits above the index must be clear
  function [7:0] reg_index;
    input [11:0] addr;
    begin
      reg_index = (addr[11:10] == 2'b00) ? addr[9:2] : 8'hff;
    end
  endfunction

  function mapped;
    input [7:0] idx;
    begin
      mapped = (idx >= `ETM_IDX_MAINT) && (idx <= `ETM_IDX_MODE);
    end
  endfunction

  // force-zeros outranks force-ones; the live and the repeated bit both use it
  function out_value;
    input [2:0] maint;
    input       bit_in;
    begin
      if (maint[`ETM_B_FORCE_ZEROS])
        out_value = 1'b0; // [R2] [R15]
      else if (maint[`ETM_B_FORCE_ONES])
        out_value = 1'b1; // [R3]
      else
        out_value = bit_in;
    end
  endfunction

  // write path: address and data latched independently, in either order
  wire [7:0] wr_idx = reg_index(wr_addr_q);
  wire       wr_go  = aw_have_q && w_have_q && !s_axi_bvalid;
  wire       wr_en  = wr_go && wr_strb_q[0];
  wire [7:0] wr_byte = wr_data_q[7:0];
  wire       aw_fire = s_axi_awvalid && s_axi_awready;
  wire       w_fire  = s_axi_wvalid && s_axi_wready;
  wire       b_done  = s_axi_bvalid && s_axi_bready;

  always @(posedge aclk) begin
    if (!aresetn) begin
      aw_have_q     <= 1'b0;
      w_have_q      <= 1'b0;
      wr_addr_q     <= 12'h000;
      wr_data_q     <= 32'h0000_0000;
      wr_strb_q     <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `ETM_RESP_OKAY;
    end else begin
      s_axi_awready <= !aw_have_q && !s_axi_awready && !wr_go;
      s_axi_wready  <= !w_have_q && !s_axi_wready && !wr_go;
      if (aw_fire) begin
        aw_have_q     <= 1'b1;
        wr_addr_q     <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (w_fire) begin
        w_have_q     <= 1'b1;
        wr_data_q    <= s_axi_wdata;
        wr_strb_q    <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end
      if (wr_go) begin
        aw_have_q    <= 1'b0;
        w_have_q     <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= mapped(wr_idx) ? `ETM_RESP_OKAY : `ETM_RESP_SLVERR;
      end else if (b_done) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // read path
  wire [7:0] rd_idx = reg_index(s_axi_araddr);
  reg  [7:0] rd_byte;
  wire       ar_fire = s_axi_arvalid && s_axi_arready;
  wire       r_done  = s_axi_rvalid && s_axi_rready;

  always @* begin
    case (rd_idx)
      `ETM_IDX_MAINT:  rd_byte = {5'h00, maint_q};
      `ETM_IDX_IRQ_EN: rd_byte = {3'h0, irq_en_q};
      `ETM_IDX_STATUS: rd_byte = {3'h0, status_q};
      `ETM_IDX_INJECT: rd_byte = {2'h0, inject_q};
      `ETM_IDX_MODE:   rd_byte = {5'h00, mode_q};
      default:         rd_byte = 8'h00;
    endcase
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= `ETM_RESP_OKAY;
    end else begin
      s_axi_arready <= !s_axi_rvalid && !s_axi_arready;
      if (ar_fire) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid  <= 1'b1;
        s_axi_rdata   <= {24'h000000, rd_byte};
        s_axi_rresp   <= mapped(rd_idx) ? `ETM_RESP_OKAY : `ETM_RESP_SLVERR;
      end else if (r_done) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // events seen on the incoming bit, in status bit order
  wire       ev_basic = tx_bit_valid && pos_basic_first;
  wire       ev_crcmf = tx_bit_valid && pos_crcmf_first;
  wire       ev_sigmf = tx_bit_valid && pos_sigmf_first;
  wire       ev_fas   = tx_bit_valid && pos_fas_first;
  wire       ev_submf = tx_bit_valid && pos_submf_first;
  wire [4:0] events   = {ev_submf, ev_fas, ev_sigmf, ev_crcmf, ev_basic};

  // which structure each injection needs, in injection bit order
  wire [5:0] inj_mode_ok = {mode_q[`ETM_B_MODE_CRC], mode_q[`ETM_B_MODE_CRC],
                            mode_q[`ETM_B_MODE_CAS], {3{mode_q[`ETM_B_MODE_BASIC]}}};
  wire [5:0] inj_rise = wr_byte[5:0] & ~inject_q;
  wire [5:0] inj_set  = (wr_en && wr_idx == `ETM_IDX_INJECT) ? inj_rise : 6'h00;

  // start conditions: an armed request begins at the first bit of its structure
  wire       start_fas1   = pos_fas_first;
  wire       start_fasall = pos_fas_first;
  wire       start_nfas   = pos_nfas_bit;
  wire       start_sigp   = pos_sigmf_first;
  wire       start_crcp   = pos_crcmf_first;
  wire       start_crc    = pos_submf_first;
  wire [5:0] start_at     = {start_crc, start_crcp, start_sigp,
                             start_nfas, start_fasall, start_fas1};
  // the bits actually inverted while a request is active
  wire       hit_fas  = pos_fas_bit;
  wire       hit_nfas = pos_nfas_bit;
  wire       hit_sigp = pos_sig_align_bit;
  wire       hit_crcp = pos_crc_align_bit;
  wire       hit_crc  = pos_crc_bit;
  wire [5:0] hit_at   = {hit_crc, hit_crcp, hit_sigp, hit_nfas, hit_fas, hit_fas};
  // end of one occurrence for the multi-bit kinds: the next structure starts, the next frame for the whole alignment word;
  // single-bit kinds never wait for an end marker
  wire [5:0] end_at = {pos_submf_first, pos_crcmf_first, pos_sigmf_first,
                       1'b0, pos_basic_first, 1'b0};
  // single-bit kinds in injection bit order
  wire [5:0] one_shot  = 6'b000101;
  wire [5:0] bit_v     = {6{tx_bit_valid}};
  wire [5:0] begin_now = armed_q & bit_v & start_at;
  // an occurrence that ends on this bit must leave it alone: the first crc bit
  // of the next sub-multiframe shares its bit with the end marker
  wire [5:0] ending    = active_q & bit_v & end_at;
  wire [5:0] run_now   = (active_q | begin_now) & ~ending;
  wire [5:0] hit_now   = run_now & hit_at & bit_v;
  // single-shot kinds finish on their first inverted bit
  wire [5:0] finish    = (hit_now & one_shot) | ending;
  wire       flip_bit  = |hit_now;

  // reset values trimmed to each register's width
  wire [7:0] rst_byte   = `ETM_RST_BYTE;
  wire [7:0] rst_mode   = `ETM_RST_MODE;
  wire [4:0] status_clr = (wr_en && wr_idx == `ETM_IDX_STATUS) ? wr_byte[4:0] : 5'h00;

  always @(posedge aclk) begin
    if (!aresetn) begin
      maint_q  <= rst_byte[2:0];
      irq_en_q <= rst_byte[4:0];
      mode_q   <= rst_mode[2:0];
      status_q <= rst_byte[4:0];
      inject_q <= rst_byte[5:0];
      armed_q  <= 6'h00;
      active_q <= 6'h00;
    end else begin
      if (wr_en && wr_idx == `ETM_IDX_MAINT) begin
        maint_q <= wr_byte[2:0];
      end
      if (wr_en && wr_idx == `ETM_IDX_IRQ_EN) begin
        irq_en_q <= wr_byte[4:0];
      end
      if (wr_en && wr_idx == `ETM_IDX_MODE) begin
        mode_q <= wr_byte[2:0];
      end
      // set wins over a simultaneous write-one clear
      status_q <= (status_q & ~status_clr) | events; // [R4] [R5] [R6]
      // a request for an absent structure is dropped at once
      armed_q  <= ((armed_q & ~begin_now) | (inj_set & inj_mode_ok)) & inj_mode_ok; // [R16]
      active_q <= (active_q | begin_now) & ~finish & inj_mode_ok;
      inject_q <= (inject_q | (inj_set & inj_mode_ok)) &
                  ~finish & inj_mode_ok; // [R14] [R16]
    end
  end

  // [R8] [R9] [R10] [R11] [R12] [R13] inversion applied to the bit in flight
  wire data_bit = tx_bit_in ^ flip_bit;

  // realignment slip: a toggle deletes the next bit if it is a one, else repeats it;
  // the choice is data dependent, which is as good as random on live traffic
  always @(posedge aclk) begin
    if (!aresetn) begin
      realign_prev_q   <= 1'b0;
      slip_pend_q      <= 1'b0;
      slip_dir_q       <= 1'b0;
      rep_pend_q       <= 1'b0;
      last_bit_q       <= 1'b0;
      tx_bit_out       <= 1'b0;
      tx_bit_out_valid <= 1'b0;
      irq              <= 1'b0;
    end else begin
      realign_prev_q <= maint_q[`ETM_B_REALIGN];
      if (maint_q[`ETM_B_REALIGN] != realign_prev_q)
        slip_pend_q <= 1'b1; // [R1]
      tx_bit_out_valid <= 1'b0;
      if (tx_bit_valid) begin
        last_bit_q <= data_bit;
        if (slip_pend_q && data_bit) begin
          slip_pend_q <= 1'b0; // [R1] delete this bit
          slip_dir_q  <= 1'b0;
        end else begin
          if (slip_pend_q) begin
            slip_pend_q <= 1'b0; // [R1] repeat this bit once more
            rep_pend_q  <= 1'b1;
            slip_dir_q  <= 1'b1;
          end
          tx_bit_out_valid <= 1'b1;
          tx_bit_out       <= out_value(maint_q, data_bit); // [R2] [R3] [R15]
        end
      end else if (rep_pend_q) begin
        rep_pend_q       <= 1'b0;
        tx_bit_out_valid <= 1'b1;
        tx_bit_out       <= out_value(maint_q, last_bit_q); // [R2] [R3] [R15]
      end
      irq <= |(status_q & irq_en_q); // [R7]
    end
  end

endmodule

// ---- verif/etm_fgen_model.sv ----
// frame generator stand-in: one bit every other cycle with its position strobes
// assumes the bench gates it with en; frames shortened to 8 bits, 16 frames per multiframe
`timescale 1ns/1ps
module etm_fgen_model (
  // clock and run control
  input  wire       aclk,
  input  wire       aresetn,
  input  wire       en,
  // stream towards the block
  output wire       bit_valid,
  output wire       bit_data,
  output wire [9:0] pos
);
  reg  [6:0] k_q;
  reg        ph_q;
  wire [2:0] b = k_q[2:0];
  wire [3:0] f = k_q[6:3];
  assign bit_valid = ph_q;
  // data keeps changing, so a frozen or slipped output shows up
  assign bit_data = k_q[0] ^ k_q[3];
  assign pos = {f == 4'h0 && b > 3'h3, k_q == 7'h00, f[0] && f < 4'hc && b == 3'h0,
                k_q == 7'h00, k_q[5:0] == 6'h00, !f[0] && b == 3'h0, f[0] && b == 3'h1,
                !f[0] && b != 3'h0, !f[0] && b == 3'h1, b == 3'h0};
  always @(posedge aclk) begin
    if (!aresetn) begin
      ph_q <= 1'b0;
      k_q  <= 7'h00;
    end else begin
      ph_q <= en & ~ph_q;
      if (ph_q) k_q <= k_q + 7'h01;
    end
  end
endmodule

// ---- verif/etm_tx_maint_properties.sv ----
// protocol and timing checks on the maintenance block ports
// assumes one clock domain and a master that offers address and data together
`timescale 1ns/1ps
module etm_tx_maint_properties (
  // clock and reset
  input wire logic        aclk,
  input wire logic        aresetn,
  // register bus
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  // stream and interrupt
  input wire logic        tx_bit_valid,
  input wire logic        tx_bit_out_valid,
  input wire logic        irq
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  AST_AW_PULSE: assert property (s_axi_awready |=> !s_axi_awready)
    else $error("awready held longer than one cycle");
  AST_B_HOLD: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped early");
  AST_R_HOLD: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped early");
  AST_R_AFTER_AR: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read data late");
  AST_B_AFTER_AW: assert property (s_axi_awvalid && s_axi_awready |-> ##[1:4] s_axi_bvalid)
    else $error("write response late");
  AST_NO_AR_BUSY: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read address taken while data pending");
  AST_OUT_NEEDS_IN: assert property (!tx_bit_valid [*3] |=> !tx_bit_out_valid)
    else $error("output bit without input bit");
  AST_IRQ_CAUSE: assert property ($rose(irq) |-> $past(tx_bit_valid, 2) || $past(s_axi_bvalid))
    else $error("interrupt rose without event or write");
  COV_IRQ: cover property ($rose(irq));
  COV_WRITE: cover property (s_axi_bvalid && s_axi_bready);
  COV_READ: cover property (s_axi_rvalid && s_axi_rready);
endmodule

bind etm_tx_maint etm_tx_maint_properties u_props (.aclk, .aresetn, .s_axi_awvalid,
  .s_axi_awready, .s_axi_bvalid, .s_axi_bready, .s_axi_bresp, .s_axi_arvalid, .s_axi_arready,
  .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .tx_bit_valid, .tx_bit_out_valid, .irq);

// ---- verif/tb_top.sv ----
// self-checking bench for the e1 transmit maintenance block
// assumes the frame generator stand-in and a register bus master built from tasks
`timescale 1ns/1ps
module tb_top;
  reg         aclk, aresetn, en, s_axi_awvalid, s_axi_wvalid, s_axi_bready;
  reg         s_axi_arvalid, s_axi_rready, in_q;
  reg  [11:0] s_axi_awaddr, s_axi_araddr;
  reg  [31:0] s_axi_wdata, rv;
  reg  [1:0]  rr;
  wire        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire        tx_bit_valid, tx_bit_in, tx_bit_out, tx_bit_out_valid, irq;
  wire [1:0]  s_axi_bresp, s_axi_rresp;
  wire [31:0] s_axi_rdata;
  wire [9:0]  pos;
  integer     num_errors, compares, nin, nout, nflip;
  integer     exp_fl [0:5] = '{1, 7, 1, 4, 6, 4};
  etm_tx_maint dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb(4'hf), .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .tx_bit_valid, .tx_bit_in, .pos_basic_first(pos[0]),
    .pos_fas_first(pos[1]), .pos_fas_bit(pos[2]), .pos_nfas_bit(pos[3]), .pos_crc_bit(pos[4]),
    .pos_submf_first(pos[5]), .pos_crcmf_first(pos[6]), .pos_crc_align_bit(pos[7]),
    .pos_sigmf_first(pos[8]), .pos_sig_align_bit(pos[9]), .tx_bit_out, .tx_bit_out_valid, .irq);
  etm_fgen_model fgen (.aclk, .aresetn, .en, .bit_valid(tx_bit_valid), .bit_data(tx_bit_in), .pos);
  initial begin
    aclk = 1'b0;
    forever #20 aclk = ~aclk;
  end
  // counters are only ever compared as differences, so nothing resets them mid-run
  always @(posedge aclk) begin
    in_q <= tx_bit_in;
    nin <= nin + tx_bit_valid;
    nout <= nout + tx_bit_out_valid;
    if (tx_bit_out_valid && tx_bit_out !== in_q) nflip <= nflip + 1;
  end
  task chk(input [31:0] got, input [31:0] exp);
    begin
      compares = compares + 1;
      if (got !== exp) begin
        num_errors = num_errors + 1;
        $display("ERROR %0t got %h expected %h", $time, got, exp);
      end
    end
  endtask
  task tally_and_finish;
    begin
      if (num_errors == 0 && compares > 0)
        $display("Run complete: PASS");
      else
        $display("Run complete: FAIL");
      $finish;
    end
  endtask
  task tmo;
    begin
      num_errors = num_errors + 1;
      $display("ERROR %0t bus wait ran out", $time);
      tally_and_finish;
    end
  endtask
  task wr(input [11:0] a, input [7:0] d);
    integer i;
    begin
      s_axi_awaddr <= a;
      s_axi_wdata <= {24'h0, d};
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      for (i = 0; i < 40; i = i + 1) begin
        @(posedge aclk);
        if (s_axi_awready) s_axi_awvalid <= 1'b0;
        if (s_axi_wready) s_axi_wvalid <= 1'b0;
        if (s_axi_bvalid) break;
      end
      if (i == 40) tmo;
      else chk(s_axi_bresp, 32'h0);
    end
  endtask
  task rd(input [11:0] a);
    integer i;
    begin
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      for (i = 0; i < 40; i = i + 1) begin
        @(posedge aclk);
        if (s_axi_arready) s_axi_arvalid <= 1'b0;
        if (s_axi_rvalid) break;
      end
      rv = s_axi_rdata;
      rr = s_axi_rresp;
      if (i == 40) tmo;
    end
  endtask
  task t_regs;
    reg [11:0] a;
    begin
      for (a = 12'h1b0; a < 12'h1c0; a = a + 12'h4) begin
        rd(a);
        chk(rv, 32'h0);
      end
      rd(12'h1c0);
      chk(rv, 32'h7);
      rd(12'h1c4);
      chk({rr, rv[29:0]}, 32'h80000000);
    end
  endtask
  task t_force;
    integer j;
    begin
      en <= 1'b1;
      for (j = 1; j < 4; j = j + 1) begin
        wr(12'h1b0, j[7:0]);
        repeat (3) @(posedge aclk);
        repeat (16) begin
          @(posedge aclk);
          if (tx_bit_out_valid) chk(tx_bit_out, j == 1);
        end
      end
      wr(12'h1b0, 8'h00);
    end
  endtask
  task t_flags;
    begin
      en <= 1'b0;
      repeat (4) @(posedge aclk);
      wr(12'h1b8, 8'h1f);
      wr(12'h1b4, 8'h1f);
      rd(12'h1b8);
      chk(rv, 32'h0);
      chk(irq, 1'b0);
      en <= 1'b1;
      repeat (260) @(posedge aclk);
      en <= 1'b0;
      repeat (4) @(posedge aclk);
      rd(12'h1b8);
      chk(rv, 32'h1f);
      chk(irq, 1'b1);
      wr(12'h1b4, 8'h01);
      wr(12'h1b8, 8'h1e);
      rd(12'h1b8);
      chk(rv, 32'h01);
      chk(irq, 1'b1);
      wr(12'h1b4, 8'h1e);
      repeat (2) @(posedge aclk);
      chk(irq, 1'b0);
      wr(12'h1b8, 8'h01);
      rd(12'h1b8);
      chk(rv, 32'h0);
    end
  endtask
  task t_inject;
    integer j, k, f0;
    begin
      en <= 1'b1;
      for (j = 0; j < 6; j = j + 1) begin
        f0 = nflip;
        wr(12'h1bc, 8'h01 << j);
        rv = 32'h1;
        for (k = 0; k < 200 && rv !== 32'h0; k = k + 1) rd(12'h1bc);
        chk(rv, 32'h0);
        repeat (3) @(posedge aclk);
        chk(nflip - f0, exp_fl[j]);
      end
      wr(12'h1c0, 8'h00);
      wr(12'h1bc, 8'h3f);
      repeat (8) @(posedge aclk);
      rd(12'h1bc);
      chk(rv, 32'h0);
      wr(12'h1c0, 8'h07);
    end
  endtask
  task t_slip;
    integer j, a0, b0, d;
    begin
      for (j = 0; j < 2; j = j + 1) begin
        en <= 1'b0;
        repeat (4) @(posedge aclk);
        a0 = nin;
        b0 = nout;
        wr(12'h1b0, j ? 8'h00 : 8'h04);
        en <= 1'b1;
        repeat (40) @(posedge aclk);
        en <= 1'b0;
        repeat (6) @(posedge aclk);
        d = (nout - b0) - (nin - a0);
        chk(d == 1 || d == -1, 1'b1);
      end
    end
  endtask
  initial begin
    {aresetn, en, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, in_q} = 0;
    {num_errors, compares, nin, nout, nflip} = 0;
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    t_regs;
    t_force;
    t_flags;
    t_inject;
    t_slip;
    tally_and_finish;
  end
endmodule
